// ---- pps_pkg.sv ----
/*
  pps_pkg: constants, pin structs and helpers shared by both ends of the
  primary bus model.
  Assumes one 40 MHz clock for both ends and a synchronous reset.
*/
package pps_pkg;
  localparam int AD_W = 32;
  localparam int BE_W = 4;
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  localparam logic [3:0] BE_ALL = 4'h0; // enables are active low
  localparam int CLAIM_WAIT = 5; // clocks after frame start
  localparam logic [1:0] RSP_OK = 2'h0;
  localparam logic [1:0] RSP_ABORT = 2'h1;
  localparam logic [1:0] RSP_STOP = 2'h2;
  localparam logic [31:0] TGT_BASE_DEF = 32'h0001_0000;
  localparam int MEM_WORDS_DEF = 16;

  // what one party drives: value and enable for every pin
  typedef struct packed {
    logic [AD_W-1:0] ad;
    logic ad_oe;
    logic [BE_W-1:0] cbe;
    logic cbe_oe;
    logic par;
    logic par_oe;
    logic frame_n;
    logic frame_oe;
    logic irdy_n;
    logic irdy_oe;
    logic trdy_n;
    logic trdy_oe;
    logic primary_target_claim_n;
    logic claim_oe;
    logic stop_n;
    logic stop_oe;
  } pps_drv_s;

  // resolved bus levels
  typedef struct packed {
    logic [AD_W-1:0] ad;
    logic [BE_W-1:0] cbe;
    logic par;
    logic frame_n;
    logic irdy_n;
    logic trdy_n;
    logic primary_target_claim_n;
    logic stop_n;
  } pps_pin_s;

  localparam pps_drv_s DRV_REL = '{frame_n: 1'h1, irdy_n: 1'h1,
    trdy_n: 1'h1, primary_target_claim_n: 1'h1, stop_n: 1'h1,
    default: '0};

  // even parity over address/data and command/enables
  function automatic logic parity(input logic [AD_W-1:0] ad,
                                  input logic [BE_W-1:0] cbe);
    return ^{ad, cbe};
  endfunction

  function automatic logic bus_idle(input pps_pin_s p);
    return p.frame_n & p.irdy_n;
  endfunction
endpackage

// ---- pps_bus_if.sv ----
/*
  pps_bus_if: the shared primary bus between the device end and the far
  end. Each end hands in values and enables; the wire levels are worked
  out here, with pull-ups on the active-low control lines.
  Assumes at most one party enables each pin at a time.
*/
`timescale 1ns/1ps
interface pps_bus_if;
  import pps_pkg::*;
  pps_drv_s dev_drv;
  pps_drv_s host_drv;
  logic gnt_n;
  pps_pin_s pin;

  // resolve each pin from the two drivers; undriven lines float to pull
  always_comb begin
    pin.ad = dev_drv.ad_oe ? dev_drv.ad :
             host_drv.ad_oe ? host_drv.ad : '0;
    pin.cbe = dev_drv.cbe_oe ? dev_drv.cbe :
              host_drv.cbe_oe ? host_drv.cbe : '0;
    pin.par = dev_drv.par_oe ? dev_drv.par :
              host_drv.par_oe ? host_drv.par : 1'h0;
    pin.frame_n = dev_drv.frame_oe ? dev_drv.frame_n :
                  host_drv.frame_oe ? host_drv.frame_n : 1'h1;
    pin.irdy_n = dev_drv.irdy_oe ? dev_drv.irdy_n :
                 host_drv.irdy_oe ? host_drv.irdy_n : 1'h1;
    pin.trdy_n = dev_drv.trdy_oe ? dev_drv.trdy_n :
                 host_drv.trdy_oe ? host_drv.trdy_n : 1'h1;
    pin.primary_target_claim_n = dev_drv.claim_oe ?
      dev_drv.primary_target_claim_n : host_drv.claim_oe ?
      host_drv.primary_target_claim_n : 1'h1;
    pin.stop_n = dev_drv.stop_oe ? dev_drv.stop_n :
                 host_drv.stop_oe ? host_drv.stop_n : 1'h1;
  end

  modport dev_end (output dev_drv, input pin, input gnt_n);
  modport host_end (output host_drv, output gnt_n, input pin);
endinterface

// ---- pps_dev_end.sv ----
/*
  pps_dev_end: primary side of the bridge. Initiator of memory write
  bursts fed from a two-entry buffer, and target with a small memory
  window for single and burst reads and writes. Parks the bus when granted.
  Assumes pps_bus_if resolves the pins and the far end arbitrates.
*/
`timescale 1ns/1ps
module pps_dev_end #(
  parameter logic [31:0] TGT_BASE = pps_pkg::TGT_BASE_DEF,
  parameter int MEM_WORDS = pps_pkg::MEM_WORDS_DEF
) (
  // clock and reset
  input logic sys_clk,
  input logic sys_rst,
  // primary bus
  pps_bus_if.dev_end bus,
  // initiator write stream
  input logic [pps_pkg::AD_W-1:0] in_data,
  input logic in_last,
  input logic in_valid,
  output logic in_ready,
  input logic [pps_pkg::AD_W-1:0] m_addr,
  // status pulses
  output logic m_done,
  output logic m_abort,
  output logic t_perr
);
  import pps_pkg::*;

  localparam int AW = $clog2(MEM_WORDS);
  localparam int DEC_LO = AW + 2;
  localparam logic [AW-1:0] T_LAST = AW'(MEM_WORDS - 1);

  typedef enum logic [2:0] {
    S_IDLE, S_M_DATA, S_M_FIN, S_T_DATA, S_T_STOP
  } pps_dev_e;

  typedef struct packed {
    logic [AD_W-1:0] data;
    logic last;
  } pps_word_s;

  typedef struct packed {
    pps_dev_e st;
    pps_drv_s drv;
    pps_word_s [1:0] fifo;
    logic [1:0] cnt;
    logic rdy;
    logic [AD_W-1:0] maddr;
    logic fresh;
    logic [2:0] wcnt;
    logic claimed;
    logic [AW-1:0] taddr;
    logic twr;
    logic fr_q;
    logic chk;
    logic chk_p;
    logic done;
    logic abort;
    logic perr;
  } pps_dev_s;

  localparam pps_dev_s RST = '{st: S_IDLE, drv: DRV_REL, fresh: 1'h1,
    rdy: 1'h1, fr_q: 1'h1, default: '0};

  pps_dev_s s;
  pps_dev_s n;
  logic [AD_W-1:0] mem [MEM_WORDS];
  logic pop;
  logic ending;
  logic mem_we;
  logic park;
  logic addr_ph;
  logic hit;
  logic xfer_m;
  logic xfer_t;
  logic claim_now;
  logic have;
  logic [1:0] c;
  logic [AW-1:0] tnext;
  pps_word_s nw;

  // next state of the whole end
  always_comb begin
    n = s;
    pop = 1'h0;
    ending = 1'h0;
    mem_we = 1'h0;
    n.done = 1'h0;
    n.abort = 1'h0;
    n.perr = 1'h0;
    n.chk = 1'h0;
    n.fr_q = bus.pin.frame_n;
    // parity trails the bus by a clock; release trails ad the same way
    n.drv.par = parity(bus.pin.ad, bus.pin.cbe);
    n.drv.par_oe = s.drv.ad_oe;
    if (s.chk && (s.chk_p != bus.pin.par)) begin
      n.perr = 1'h1;
    end
    park = !bus.gnt_n && bus_idle(bus.pin);
    addr_ph = !bus.pin.frame_n && s.fr_q;
    hit = addr_ph && (bus.pin.cbe == CMD_MEM_RD ||
          bus.pin.cbe == CMD_MEM_WR) &&
          bus.pin.ad[AD_W-1:DEC_LO] == TGT_BASE[AD_W-1:DEC_LO];
    xfer_m = s.drv.irdy_oe && !s.drv.irdy_n && !bus.pin.trdy_n;
    xfer_t = s.drv.trdy_oe && !s.drv.trdy_n && !bus.pin.irdy_n;
    claim_now = s.claimed || !bus.pin.primary_target_claim_n;
    tnext = xfer_t ? AW'(s.taddr + 1'h1) : s.taddr;
    have = 1'h0;
    nw = s.fifo[0];
    unique case (s.st)
      S_IDLE: begin
        // lines driven high last clock are let go now
        n.drv.frame_oe = 1'h0;
        n.drv.irdy_oe = 1'h0;
        n.drv.trdy_oe = 1'h0;
        n.drv.claim_oe = 1'h0;
        n.drv.stop_oe = 1'h0;
        n.drv.ad_oe = park;
        n.drv.cbe_oe = park;
        // parked address lines carry the current write address s.maddr
        n.drv.ad = s.maddr;
        if (hit) begin
          n.drv.ad_oe = 1'h0;
          n.drv.cbe_oe = 1'h0;
          n.st = S_T_DATA;
          n.taddr = bus.pin.ad[DEC_LO-1:2];
          n.twr = bus.pin.cbe == CMD_MEM_WR;
          n.chk = 1'h1;
          n.chk_p = parity(bus.pin.ad, bus.pin.cbe);
          // claim now, ready one clock later for turnaround
          n.drv.primary_target_claim_n = 1'h0;
          n.drv.claim_oe = 1'h1;
          n.drv.trdy_n = 1'h1;
          n.drv.trdy_oe = 1'h1;
          n.drv.stop_n = 1'h1;
          n.drv.stop_oe = 1'h1;
        end else if (park && s.cnt != 2'h0) begin
          n.st = S_M_DATA;
          n.maddr = s.fresh ? m_addr : s.maddr;
          n.fresh = 1'h0;
          n.drv.ad = n.maddr;
          n.drv.cbe = CMD_MEM_WR;
          n.drv.frame_n = 1'h0;
          n.drv.frame_oe = 1'h1;
          n.drv.irdy_n = 1'h1;
          n.drv.irdy_oe = 1'h1;
          n.wcnt = 3'h0;
          n.claimed = 1'h0;
        end
      end
      S_M_DATA: begin
        n.claimed = claim_now;
        if (s.wcnt != 3'(CLAIM_WAIT)) begin
          n.wcnt = s.wcnt + 3'h1;
        end
        pop = xfer_m;
        if (!claim_now && s.wcnt == 3'(CLAIM_WAIT)) begin
          // nobody claimed: drop the word, no data went out
          pop = 1'h1;
          n.abort = 1'h1;
          ending = 1'h1;
        end else if (xfer_m && s.fifo[0].last) begin
          n.done = 1'h1;
          ending = 1'h1;
        end else if (!bus.pin.stop_n) begin
          ending = 1'h1;
        end else begin
          have = xfer_m ? s.cnt == 2'h2 : s.cnt != 2'h0;
          nw = xfer_m ? s.fifo[1] : s.fifo[0];
          // a held ready keeps its word until the phase completes
          if (s.drv.irdy_n || xfer_m) begin
            n.drv.irdy_n = !have;
            n.drv.ad = nw.data;
            n.drv.cbe = BE_ALL;
            n.drv.frame_n = have && nw.last;
          end
        end
        if (ending && !s.drv.frame_n) begin
          // frame goes high first, ready follows a clock later
          n.st = S_M_FIN;
          n.drv.frame_n = 1'h1;
          // frame may only rise with ready low, even with no word held
          n.drv.irdy_n = 1'h0;
        end else if (ending) begin
          n.st = S_IDLE;
          n.drv.irdy_n = 1'h1;
          n.drv.frame_oe = 1'h0;
          n.drv.ad_oe = 1'h0;
          n.drv.cbe_oe = 1'h0;
        end
      end
      S_M_FIN: begin
        pop = xfer_m;
        n.done = xfer_m && s.fifo[0].last;
        n.st = S_IDLE;
        n.drv.irdy_n = 1'h1;
        n.drv.frame_oe = 1'h0;
        n.drv.ad_oe = 1'h0;
        n.drv.cbe_oe = 1'h0;
      end
      S_T_DATA: begin
        n.drv.trdy_n = 1'h0;
        n.drv.ad = mem[tnext];
        n.drv.ad_oe = !s.twr;
        n.taddr = tnext;
        if (xfer_t) begin
          mem_we = s.twr;
          n.chk = s.twr;
          n.chk_p = parity(bus.pin.ad, bus.pin.cbe);
          if (bus.pin.frame_n) begin
            n.st = S_IDLE;
            n.drv.trdy_n = 1'h1;
            n.drv.primary_target_claim_n = 1'h1;
            n.drv.ad_oe = 1'h0;
          end else if (s.taddr == T_LAST) begin
            // window ends here: ask the initiator to stop
            n.st = S_T_STOP;
            n.drv.trdy_n = 1'h1;
            n.drv.stop_n = 1'h0;
            n.drv.ad_oe = 1'h0;
          end
        end
      end
      S_T_STOP: begin
        if (bus.pin.frame_n) begin
          n.st = S_IDLE;
          n.drv.stop_n = 1'h1;
          n.drv.primary_target_claim_n = 1'h1;
        end
      end
      default: n.st = S_IDLE;
    endcase
    // two-entry buffer; a stall downstream only drops ready
    c = s.cnt - {1'h0, pop};
    if (pop) begin
      n.fifo[0] = s.fifo[1];
      n.maddr = s.maddr + 32'h4;
      n.fresh = s.fifo[0].last;
    end
    if (in_valid && s.rdy) begin
      n.fifo[c[0]] = '{data: in_data, last: in_last};
      c = c + 2'h1;
    end
    n.cnt = c;
    n.rdy = c != 2'h2;
  end

  // all state but the target window in one register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s <= RST;
    end else begin
      s <= n;
    end
  end

  // target window, byte enables are active low
  always_ff @(posedge sys_clk) begin
    if (mem_we) begin
      for (int b = 0; b < BE_W; b++) begin
        if (!bus.pin.cbe[b]) begin
          mem[s.taddr][b*8 +: 8] <= bus.pin.ad[b*8 +: 8];
        end
      end
    end
  end

  assign bus.dev_drv = s.drv;
  assign in_ready = s.rdy;
  assign m_done = s.done;
  assign m_abort = s.abort;
  assign t_perr = s.perr;
endmodule // pps_dev_end

// ---- pps_host_end.sv ----
/*
  pps_host_end: the far party on the primary bus. Arbiter for the grant,
  single-phase initiator on a command port, and a write-only target that
  can be told to ignore or to stop the device's bursts.
  Assumes pps_bus_if resolves the pins.
*/
`timescale 1ns/1ps
module pps_host_end (
  // clock and reset
  input logic sys_clk,
  input logic sys_rst,
  // primary bus
  pps_bus_if.host_end bus,
  // command port
  input logic cmd_valid,
  output logic cmd_ready,
  input logic cmd_write,
  input logic [pps_pkg::AD_W-1:0] cmd_addr,
  input logic [pps_pkg::AD_W-1:0] cmd_data,
  // response port
  output logic rsp_valid,
  output logic [pps_pkg::AD_W-1:0] rsp_data,
  output logic [1:0] rsp_status,
  // target side
  input logic tgt_claim_en,
  input logic tgt_stop_en,
  output logic wd_valid,
  output logic [pps_pkg::AD_W-1:0] wd_data
);
  import pps_pkg::*;

  typedef enum logic [2:0] {
    H_IDLE, H_WAIT, H_DATA, H_T_DATA, H_T_STOP
  } pps_host_e;

  typedef struct packed {
    pps_host_e st;
    pps_drv_s drv;
    logic gnt_n;
    logic pend;
    logic rdy;
    logic cwr;
    logic [AD_W-1:0] caddr;
    logic [AD_W-1:0] cdata;
    logic [2:0] wcnt;
    logic claimed;
    logic fr_q;
    logic rsp_valid;
    logic [AD_W-1:0] rsp_data;
    logic [1:0] rsp_status;
    logic wd_valid;
    logic [AD_W-1:0] wd_data;
  } pps_host_s;

  localparam pps_host_s RST = '{st: H_IDLE, drv: DRV_REL, gnt_n: 1'h1,
    rdy: 1'h1, fr_q: 1'h1, default: '0};

  pps_host_s s;
  pps_host_s n;
  logic hit;
  logic xfer_m;
  logic xfer_t;
  logic claim_now;

  // next state
  always_comb begin
    n = s;
    n.rsp_valid = 1'h0;
    n.wd_valid = 1'h0;
    n.fr_q = bus.pin.frame_n;
    n.drv.par = parity(bus.pin.ad, bus.pin.cbe);
    n.drv.par_oe = s.drv.ad_oe;
    hit = !bus.pin.frame_n && s.fr_q && tgt_claim_en &&
          bus.pin.cbe == CMD_MEM_WR;
    xfer_m = s.drv.irdy_oe && !s.drv.irdy_n && !bus.pin.trdy_n;
    xfer_t = s.drv.trdy_oe && !s.drv.trdy_n && !bus.pin.irdy_n;
    claim_now = s.claimed || !bus.pin.primary_target_claim_n;
    if (cmd_valid && s.rdy) begin
      n.pend = 1'h1;
      n.cwr = cmd_write;
      n.caddr = cmd_addr;
      n.cdata = cmd_data;
    end
    unique case (s.st)
      H_IDLE, H_WAIT: begin
        n.drv.frame_oe = 1'h0;
        n.drv.irdy_oe = 1'h0;
        n.drv.trdy_oe = 1'h0;
        n.drv.claim_oe = 1'h0;
        n.drv.stop_oe = 1'h0;
        n.drv.ad_oe = 1'h0;
        n.drv.cbe_oe = 1'h0;
        n.gnt_n = !(s.st == H_IDLE && !s.pend);
        if (s.st == H_WAIT && s.wcnt != 3'h7) begin
          n.wcnt = s.wcnt + 3'h1;
        end
        if (hit) begin
          n.st = H_T_DATA;
          n.drv.primary_target_claim_n = 1'h0;
          n.drv.claim_oe = 1'h1;
          n.drv.trdy_n = 1'h1;
          n.drv.trdy_oe = 1'h1;
          n.drv.stop_n = 1'h1;
          n.drv.stop_oe = 1'h1;
        end else if (s.st == H_IDLE && s.pend) begin
          n.st = H_WAIT;
          n.wcnt = 3'h0;
        end else if (s.st == H_WAIT && s.wcnt != 3'h0 &&
                     bus_idle(bus.pin)) begin
          // grant has been off a full clock, the device let go
          n.st = H_DATA;
          n.drv.ad = s.caddr;
          n.drv.ad_oe = 1'h1;
          n.drv.cbe = s.cwr ? CMD_MEM_WR : CMD_MEM_RD;
          n.drv.cbe_oe = 1'h1;
          n.drv.frame_n = 1'h0;
          n.drv.frame_oe = 1'h1;
          n.drv.irdy_n = 1'h1;
          n.drv.irdy_oe = 1'h1;
          n.wcnt = 3'h0;
          n.claimed = 1'h0;
        end
      end
      H_DATA: begin
        n.claimed = claim_now;
        if (s.wcnt != 3'(CLAIM_WAIT)) begin
          n.wcnt = s.wcnt + 3'h1;
        end
        // single phase: frame off as ready comes on
        n.drv.frame_n = 1'h1;
        n.drv.irdy_n = 1'h0;
        n.drv.cbe = BE_ALL;
        n.drv.ad = s.cdata;
        n.drv.ad_oe = s.cwr;
        if (xfer_m || !bus.pin.stop_n ||
            (!claim_now && s.wcnt == 3'(CLAIM_WAIT))) begin
          n.rsp_valid = 1'h1;
          n.rsp_data = bus.pin.ad;
          n.rsp_status = xfer_m ? RSP_OK :
                         !bus.pin.stop_n ? RSP_STOP : RSP_ABORT;
          n.pend = 1'h0;
          n.st = H_IDLE;
          n.drv.irdy_n = 1'h1;
          n.drv.frame_oe = 1'h0;
          n.drv.ad_oe = 1'h0;
          n.drv.cbe_oe = 1'h0;
        end
      end
      H_T_DATA: begin
        n.drv.trdy_n = 1'h0;
        if (xfer_t) begin
          n.wd_valid = 1'h1;
          n.wd_data = bus.pin.ad;
          if (bus.pin.frame_n) begin
            n.st = H_IDLE;
            n.drv.trdy_n = 1'h1;
            n.drv.primary_target_claim_n = 1'h1;
          end else if (tgt_stop_en) begin
            n.st = H_T_STOP;
            n.drv.trdy_n = 1'h1;
            n.drv.stop_n = 1'h0;
          end
        end
      end
      H_T_STOP: begin
        if (bus.pin.frame_n) begin
          n.st = H_IDLE;
          n.drv.stop_n = 1'h1;
          n.drv.primary_target_claim_n = 1'h1;
        end
      end
      default: n.st = H_IDLE;
    endcase
    n.rdy = !n.pend;
  end

  // all state in one register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s <= RST;
    end else begin
      s <= n;
    end
  end

  assign bus.host_drv = s.drv;
  assign bus.gnt_n = s.gnt_n;
  assign cmd_ready = s.rdy;
  assign rsp_valid = s.rsp_valid;
  assign rsp_data = s.rsp_data;
  assign rsp_status = s.rsp_status;
  assign wd_valid = s.wd_valid;
  assign wd_data = s.wd_data;
endmodule // pps_host_end

// ---- pps_bus_monitor.sv ----
/*
  pps_bus_monitor: concurrent checks on the shared primary bus, watching
  both ends' drive values, the grant and the resolved pin levels.
  Assumes one clock domain and the synchronous active-high reset.
*/
`timescale 1ns/1ps
module pps_bus_monitor #(
  parameter logic [31:0] TGT_BASE = pps_pkg::TGT_BASE_DEF,
  parameter int MEM_WORDS = pps_pkg::MEM_WORDS_DEF
) (
  // clock and reset
  input logic sys_clk,
  input logic sys_rst,
  // drivers, grant and levels
  input pps_pkg::pps_drv_s dev_drv,
  input pps_pkg::pps_drv_s host_drv,
  input logic gnt_n,
  input pps_pkg::pps_pin_s pin
);
  import pps_pkg::*;
  localparam int AW = $clog2(MEM_WORDS);
  logic idle_gnt;
  logic tgt_hit;

  // parked bus and a host access aimed at the device window
  assign idle_gnt = !gnt_n && pin.frame_n && pin.irdy_n;
  assign tgt_hit = host_drv.frame_oe && pin.ad[31:AW+2] == TGT_BASE[31:AW+2]
    && (pin.cbe == CMD_MEM_RD || pin.cbe == CMD_MEM_WR);

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  AST_DEV_INIT_STS: assert property (
    ($fell(dev_drv.frame_oe) |-> $past(dev_drv.frame_n)) and
    ($fell(dev_drv.irdy_oe) |-> $past(dev_drv.irdy_n)))
    else $error("device frame or ready released while low");
  AST_DEV_TGT_STS: assert property (
    ($fell(dev_drv.trdy_oe) |-> $past(dev_drv.trdy_n)) and
    ($fell(dev_drv.claim_oe) |-> $past(dev_drv.primary_target_claim_n))
    and ($fell(dev_drv.stop_oe) |-> $past(dev_drv.stop_n)))
    else $error("device target line released while low");
  AST_HOST_STS: assert property (
    ($fell(host_drv.frame_oe) |-> $past(host_drv.frame_n)) and
    ($fell(host_drv.irdy_oe) |-> $past(host_drv.irdy_n)))
    else $error("host frame or ready released while low");
  AST_PAR_EVEN: assert property (
    (dev_drv.par_oe || host_drv.par_oe) |->
    pin.par == ^{$past(pin.ad), $past(pin.cbe)})
    else $error("parity line does not make ones count even");
  AST_PAR_TRAIL: assert property (
    $fell(dev_drv.ad_oe) |-> dev_drv.par_oe ##1 !dev_drv.par_oe)
    else $error("parity not released one clock after address lines");
  AST_READ_PAR: assert property (
    $fell(dev_drv.trdy_n) && dev_drv.ad_oe |=> dev_drv.par_oe)
    else $error("read parity not driven after target ready");
  AST_PARK: assert property (
    idle_gnt [*4] |-> dev_drv.ad_oe && dev_drv.cbe_oe && dev_drv.par_oe)
    else $error("granted idle bus not parked by device");
  AST_DEV_CMD: assert property (
    $fell(dev_drv.frame_n) && dev_drv.frame_oe |->
    dev_drv.ad_oe && dev_drv.cbe == CMD_MEM_WR
    ##1 dev_drv.cbe == BE_ALL && !dev_drv.irdy_n)
    else $error("device address phase command or enables wrong");
  AST_ABORT: assert property (
    $fell(dev_drv.frame_n) && dev_drv.frame_oe
    ##1 pin.primary_target_claim_n [*5] |=> pin.frame_n ##1 pin.irdy_n)
    else $error("no master abort after five clocks without claim");
  AST_CLAIM: assert property (
    $fell(pin.frame_n) && tgt_hit |=>
    !pin.primary_target_claim_n && dev_drv.claim_oe ##1 !dev_drv.trdy_n)
    else $error("device target did not claim its window");
  AST_TRDY_HOLD: assert property (
    dev_drv.trdy_oe && !dev_drv.trdy_n && pin.irdy_n |=> !dev_drv.trdy_n)
    else $error("target ready dropped before transfer");
  AST_IRDY_HOLD: assert property (
    dev_drv.frame_oe && !dev_drv.frame_n && !dev_drv.irdy_n && pin.trdy_n
    |=> !dev_drv.irdy_n)
    else $error("initiator ready dropped before transfer");
  AST_FRAME_LAST: assert property (
    $rose(dev_drv.frame_n) && dev_drv.frame_oe |->
    dev_drv.irdy_oe && !dev_drv.irdy_n)
    else $error("frame raised without initiator ready");
endmodule // pps_bus_monitor

// ---- tb.sv ----
/*
  tb: both ends of the primary bus joined by one interface, with a bench
  model of the device window and of the words the device sends out.
  Assumes the package, interface, both ends and the monitor come first.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((e) !== (g)) begin \
  n_errors++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module tb;
  import pps_pkg::*;
  logic sys_clk, sys_rst, in_last, in_valid, in_ready, m_done, m_abort;
  logic t_perr, cmd_valid, cmd_ready, cmd_write, rsp_valid, wd_valid;
  logic tgt_claim_en, tgt_stop_en;
  logic [31:0] in_data, m_addr, cmd_addr, cmd_data, rsp_data, wd_data;
  logic [31:0] rnd, rd, exp_w;
  logic [1:0] rsp_status, st;
  logic [31:0] mem [16];
  logic written [16];
  logic [31:0] exp_wd [$];
  int n_errors, n_checks, n_done, n_abort, i, j, k, idx, d0, a0;

  pps_bus_if bus ();
  pps_dev_end u_pps_dev_end (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .bus(bus), .in_data(in_data), .in_last(in_last), .in_valid(in_valid),
    .in_ready(in_ready), .m_addr(m_addr), .m_done(m_done),
    .m_abort(m_abort), .t_perr(t_perr));
  pps_host_end u_pps_host_end (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .bus(bus), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_status(rsp_status),
    .tgt_claim_en(tgt_claim_en), .tgt_stop_en(tgt_stop_en),
    .wd_valid(wd_valid), .wd_data(wd_data));
  pps_bus_monitor u_pps_bus_monitor (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .dev_drv(bus.dev_drv), .host_drv(bus.host_drv), .gnt_n(bus.gnt_n),
    .pin(bus.pin));

  // 40 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task give_verdict;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task fail_wait;
    n_errors++;
    $display("MISMATCH timeout exp 1 got 0");
    give_verdict;
  endtask

  // words seen at the far end and status pulses, pre-edge values
  always @(posedge sys_clk) begin
    if (!sys_rst && wd_valid === 1'b1) begin
      exp_w = exp_wd.size() > 0 ? exp_wd.pop_front() : ~wd_data;
      `CHK("wd_data", exp_w, wd_data)
    end
    if (!sys_rst && t_perr !== 1'b0) `CHK("t_perr", 1'b0, t_perr)
    n_done += (m_done === 1'b1);
    n_abort += (m_abort === 1'b1);
  end

  // back to back words so the two-entry buffer fills and refuses
  task send_burst(input int n, input logic keep);
    for (k = 0; k < n; k++) begin
      rnd = lfsr(rnd);
      in_data <= rnd;
      in_valid <= 1'b1;
      in_last <= (k == n - 1);
      if (keep) exp_wd.push_back(rnd);
      i = 0;
      do begin @(posedge sys_clk); i++; end
      while (in_ready !== 1'b1 && i < 200);
      if (i >= 200) fail_wait;
    end
    in_valid <= 1'b0;
  endtask

  task do_cmd(input logic wr, input logic [31:0] a, input logic [31:0] d);
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_addr <= a;
    cmd_data <= d;
    i = 0;
    do begin @(posedge sys_clk); i++; end
    while (cmd_ready !== 1'b1 && i < 200);
    cmd_valid <= 1'b0;
    do begin @(posedge sys_clk); i++; end
    while (rsp_valid !== 1'b1 && i < 400);
    if (i >= 400) fail_wait;
    rd = rsp_data;
    st = rsp_status;
  endtask

  // main sequence
  initial begin
    sys_rst = 1'b1;
    {in_last, in_valid, cmd_valid, cmd_write} = 4'h0;
    {in_data, cmd_addr, cmd_data} = '0;
    m_addr = 32'h0002_0000;
    tgt_claim_en = 1'b1;
    tgt_stop_en = 1'b0;
    rnd = 32'h8D210CE9;
    for (j = 0; j < 16; j++) written[j] = 1'b0;
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    // window writes at both ends of the window, then read back
    for (j = 0; j < 6; j++) begin
      rnd = lfsr(rnd);
      idx = j == 0 ? 0 : j == 1 ? 15 : int'(rnd[7:4]);
      mem[idx] = rnd;
      written[idx] = 1'b1;
      do_cmd(1'b1, TGT_BASE_DEF + 32'(idx * 4), rnd);
      `CHK("wr_status", RSP_OK, st)
    end
    for (j = 0; j < 16; j++) begin
      if (written[j]) begin
        do_cmd(1'b0, TGT_BASE_DEF + 32'(j * 4), 32'h0);
        `CHK("rd_status", RSP_OK, st)
        `CHK("rd_data", mem[j], rd)
      end
    end
    // nobody claims this address
    do_cmd(1'b0, 32'h0004_0000, 32'h0);
    `CHK("abort_status", RSP_ABORT, st)
    // device bursts: plain, stopped after each word, never claimed
    for (j = 0; j < 3; j++) begin
      tgt_claim_en <= (j != 2);
      tgt_stop_en <= (j == 1);
      d0 = n_done;
      a0 = n_abort;
      send_burst(5, j != 2);
      i = 0;
      do begin @(negedge sys_clk); i++; end
      while ((n_done + n_abort < d0 + a0 + (j == 2 ? 5 : 1) ||
              exp_wd.size() != 0) && i < 600);
      if (i >= 600) fail_wait;
      @(posedge sys_clk);
      `CHK("m_done", d0 + (j != 2), n_done)
      `CHK("m_abort", a0 + (j == 2 ? 5 : 0), n_abort)
    end
    give_verdict;
  end
endmodule // tb
